// ---- common/shift_unit_consts.vh ----
/*
 * constants for the shift and carry unit: opcodes, widths, state counts.
 * assumes inclusion by bare name from the design files.
 */
`ifndef SHIFT_UNIT_CONSTS_VH
`define SHIFT_UNIT_CONSTS_VH

// ****************************************************************
// opcodes
// ****************************************************************
`define OP_SET_CARRY 8'hF9
`define OP_LEFT_WORD 8'h09
`define OP_LEFT_BYTE 8'h19
`define OP_LEFT_DOUBLE 8'h0D
`define OP_LRIGHT_WORD 8'h08
`define OP_LRIGHT_BYTE 8'h18
`define OP_ARIGHT_WORD 8'h0A
`define OP_ARIGHT_BYTE 8'h1A
`define OP_ARIGHT_DOUBLE 8'h0E

// ****************************************************************
// widths, kinds, count sources
// ****************************************************************
`define W_BYTE 2'h0
`define W_WORD 2'h1
`define W_DOUBLE 2'h2
`define K_LEFT 2'h0
`define K_LRIGHT 2'h1
`define K_ARIGHT 2'h2
`define K_SET_CARRY_OP 2'h3
`define IMM_MAX 8'h0F
`define REG_ADDR_MIN 8'h10

// ****************************************************************
// instruction lengths and state counts
// ****************************************************************
`define SHIFT_BYTES 2'h3
`define SET_CARRY_OP_BYTES 2'h1
`define SET_CARRY_OP_STATES 6'h04
`define SHIFT_BASE_STATES 6'h07
`define ZERO_SHIFT_STATES 6'h08

`endif

// ---- testbench/shift_unit_checker_assertions.sv ----
/* port checker for the shift and carry unit.
   assumes start_i stays low until the reset sync has let go. */
`timescale 1ns/1ps
`default_nettype none
`include "shift_unit_consts.vh"
module shift_unit_checker (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic enable_i,
    input wire logic start_i,
    input wire logic [7:0] opcode_i,
    input wire logic [7:0] count_byte_i,
    input wire logic [7:0] count_reg_data_i,
    input wire logic carry_i,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic illegal_o,
    input wire logic [31:0] result_o,
    input wire logic carry_flag_o,
    input wire logic sticky_flag_o,
    input wire logic write_result_o,
    input wire logic zero_flag_o,
    input wire logic [1:0] length_o,
    input wire logic [5:0] states_o
);
    wire take = enable_i && start_i && !busy_o;
    wire set_carry_op = opcode_i == `OP_SET_CARRY;
    wire right = opcode_i inside {`OP_LRIGHT_WORD, `OP_LRIGHT_BYTE,
        `OP_ARIGHT_WORD, `OP_ARIGHT_BYTE, `OP_ARIGHT_DOUBLE};
    wire shift = right || opcode_i inside {`OP_LEFT_WORD, `OP_LEFT_BYTE,
        `OP_LEFT_DOUBLE};
    wire [4:0] cnt = count_byte_i <= `IMM_MAX ? count_byte_i[4:0]
        : count_reg_data_i[4:0];
    wire [5:0] exp_st = cnt == 5'h00 ? `ZERO_SHIFT_STATES
        : `SHIFT_BASE_STATES + {1'b0, cnt};
    // counts only enabled busy edges, so stalls never look like slips;
    // the taking edge is the first state
    logic [5:0] cyc;
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) cyc <= 6'h00;
        else if (take) cyc <= 6'h01;
        else if (enable_i && busy_o) cyc <= cyc + 6'h01;
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    a_set_carry_op_done: assert property (
        take && set_carry_op ##1 enable_i [*3] |=>
        done_o && carry_flag_o && !write_result_o)
        else $error("set carry did not end as expected");
    a_set_carry_op_len: assert property (
        take && set_carry_op |=> states_o == `SET_CARRY_OP_STATES && length_o == `SET_CARRY_OP_BYTES)
        else $error("set carry length or states wrong");
    a_shift_states: assert property (
        take && shift |=> states_o == $past(exp_st) &&
        length_o == `SHIFT_BYTES)
        else $error("shift length or states wrong");
    a_done_timing: assert property (
        done_o |-> cyc == states_o) else $error("done at wrong edge");
    a_done_pulse: assert property (
        done_o && enable_i |=> !done_o)
        else $error("done longer than one cycle");
    a_busy_refuse: assert property (
        busy_o && start_i |=> $stable(states_o) && $stable(length_o))
        else $error("start taken while busy");
    a_write_shift: assert property (
        write_result_o |-> done_o && length_o == `SHIFT_BYTES)
        else $error("result written outside a shift");
    a_zero_flag: assert property (
        write_result_o |-> zero_flag_o == (result_o == 32'h0))
        else $error("zero flag does not match result");
    a_illegal_op: assert property (
        take && !set_carry_op && !shift |=> illegal_o && !busy_o)
        else $error("unknown opcode not flagged");
    a_sticky_one: assert property (
        take && right && cnt == 5'h01 ##1 enable_i [*7] |=>
        done_o && !sticky_flag_o) else $error("sticky set on one step");
    c_right: cover property (take && right);
    c_sticky: cover property (done_o && sticky_flag_o);
    c_illegal: cover property (illegal_o);
endmodule // shift_unit_checker
bind shift_and_carry_unit shift_unit_checker u_shift_unit_checker (.*);
`default_nettype wire

// ---- testbench/tb_shift_and_carry_unit.sv ----
/* self-checking bench for the shift and carry unit.
   assumes the unit's constants header is on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "shift_unit_consts.vh"
module tb_shift_and_carry_unit;
    logic clock_i = 0, nrst_i = 0, enable_i = 1, start_i = 0;
    logic [7:0] opcode_i = 0, count_byte_i = 0, count_reg_data_i = 0;
    logic [31:0] operand_i = 0, result_o, v;
    logic carry_i = 0, sticky_i = 0, zero_i = 0, ci;
    logic busy_o, done_o, illegal_o, carry_flag_o, sticky_flag_o;
    logic zero_flag_o, write_result_o;
    logic [1:0] length_o;
    logic [5:0] states_o;
    logic [7:0] count_reg_addr_o, cb, rd;
    int num_errors = 0, checked = 0;
    localparam logic [7:0] ops [8] = '{`OP_LEFT_WORD, `OP_LEFT_BYTE,
        `OP_LEFT_DOUBLE, `OP_LRIGHT_WORD, `OP_LRIGHT_BYTE,
        `OP_ARIGHT_WORD, `OP_ARIGHT_BYTE, `OP_ARIGHT_DOUBLE};
    shift_and_carry_unit u_shift_and_carry_unit (.*);
    initial forever #4 clock_i = ~clock_i;
    task chk(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task stop_test;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ****************************************************************
    // reference: one bit per step, as the unit walks it
    // ****************************************************************
    function automatic logic [34:0] model(input logic [7:0] op,
        input logic [4:0] n, input logic [31:0] d, input logic c, s);
        int w;
        logic [31:0] m, x, fill;
        logic r;
        w = op inside {`OP_LEFT_BYTE, `OP_LRIGHT_BYTE, `OP_ARIGHT_BYTE} ? 8
            : op inside {`OP_LEFT_DOUBLE, `OP_ARIGHT_DOUBLE} ? 32 : 16;
        m = 32'hFFFFFFFF >> (32 - w);
        x = d & m;
        r = op inside {`OP_LRIGHT_WORD, `OP_LRIGHT_BYTE, `OP_ARIGHT_WORD,
            `OP_ARIGHT_BYTE, `OP_ARIGHT_DOUBLE};
        fill = op inside {`OP_ARIGHT_WORD, `OP_ARIGHT_BYTE, `OP_ARIGHT_DOUBLE}
            && x[w-1] ? 32'h1 << (w - 1) : 32'h0;
        s = r ? 1'b0 : s;
        for (int i = 0; i < n; i++) begin
            if (r) begin
                s = s | (c && i > 0);
                c = x[0];
                x = (x >> 1) | fill;
            end else begin
                c = x[w-1];
                x = (x << 1) & m;
            end
        end
        return {x, c, s, x == 32'h0};
    endfunction
    // stall > 0 also holds start high one more cycle, which must be refused
    task run(input logic [7:0] op, c, r, input logic [31:0] d,
        input logic fc, fs, fz, input int stall);
        logic [4:0] n;
        logic [34:0] e;
        logic [5:0] st;
        int k;
        n = c <= `IMM_MAX ? c[4:0] : r[4:0];
        e = model(op, n, d, fc, fs);
        st = op == `OP_SET_CARRY ? 6'h04 : n == 5'h00 ? 6'h08 : 6'h07 + n;
        if (op == `OP_SET_CARRY) e = {32'h0, 1'b1, fs, fz};
        {opcode_i, count_byte_i, count_reg_data_i, operand_i} = {op, c, r, d};
        {carry_i, sticky_i, zero_i, start_i} = {fc, fs, fz, 1'b1};
        @(negedge clock_i);
        start_i = stall > 0;
        // the taking edge counts as the first state
        k = 1;
        while (done_o !== 1'b1 && k < 80) begin
            @(negedge clock_i);
            k++;
            start_i = 0;
            enable_i = !(k >= 2 && k < 2 + stall);
        end
        chk("edges", st + stall, k);
        chk("states", st, states_o);
        chk("length", op == `OP_SET_CARRY ? 1 : 3, length_o);
        chk("count addr", c, count_reg_addr_o);
        chk("carry", e[2], carry_flag_o);
        chk("sticky", e[1], sticky_flag_o);
        chk("zero", e[0], zero_flag_o);
        chk("write", op != `OP_SET_CARRY, write_result_o);
        if (op != `OP_SET_CARRY)
            chk("result", e[34:3], result_o);
    endtask
    initial begin
        void'($urandom(32'h30a1));
        repeat (20) @(negedge clock_i);
        nrst_i = 1;
        repeat (3) @(negedge clock_i);
        for (int i = 0; i < 8; i++)
            run(`OP_SET_CARRY, 0, 0, $urandom, i[0], i[1], i[2], 0);
        $display("test set carry done");
        foreach (ops[j]) begin
            for (int i = 0; i < 24; i++) begin
                cb = i < 2 ? 8'(i * 15) : i == 2 ? 8'h10 : i == 3 ? 8'hFF
                    : $urandom % 2 ? 8'($urandom % 16) : 8'($urandom);
                rd = i == 2 ? 8'h1F : 8'($urandom);
                v = i == 4 ? 32'h80008080 : $urandom;
                ci = 1'($urandom);
                run(ops[j], cb, rd, v, ci, 1'($urandom), 1'($urandom),
                    i == 5 ? 3 : 0);
            end
            $display("test opcode %h done", ops[j]);
        end
        {opcode_i, start_i} = {8'h00, 1'b1};
        @(negedge clock_i);
        start_i = 0;
        chk("illegal", 1, illegal_o);
        chk("busy", 0, busy_o);
        $display("test unknown opcode done");
        stop_test;
    end
    initial begin
        #200000;
        num_errors++;
        stop_test;
    end
endmodule // tb_shift_and_carry_unit
`default_nettype wire

// ---- verilog/shift_and_carry_unit.v ----
/*
 * shift and carry unit: set-carry and byte/word/double shifts, one
 * bit per state, with carry, sticky and zero flag updates.
 * assumes the decoder presents opcode, count byte and operands with
 * a one-cycle start strobe; one enabled clock cycle stands for one state.
 */
`timescale 1ns/1ps
`default_nettype none
`include "shift_unit_consts.vh"

module shift_and_carry_unit (
    input wire clock_i,
    input wire nrst_i,
    input wire enable_i,
    input wire start_i,
    input wire [7:0] opcode_i,
    input wire [7:0] count_byte_i,
    input wire [7:0] count_reg_data_i,
    input wire [31:0] operand_i,
    input wire carry_i,
    input wire sticky_i,
    input wire zero_i,
    output reg busy_o,
    output reg done_o,
    output reg illegal_o,
    output reg [31:0] result_o,
    output reg carry_flag_o,
    output reg sticky_flag_o,
    output reg zero_flag_o,
    output reg write_result_o,
    output reg [1:0] length_o,
    output reg [5:0] states_o,
    output reg [7:0] count_reg_addr_o
);

    // ****************************************************************
    // reset release
    // ****************************************************************
    reg rst_meta;
    reg rst_sync;

    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    wire rst_n = rst_sync;

    // ****************************************************************
    // decode
    // ****************************************************************
    wire dec_valid;
    wire [1:0] dec_kind;
    wire [1:0] dec_width;

    shift_decode u_decode (
        .opcode_i(opcode_i),
        .valid_o(dec_valid),
        .kind_o(dec_kind),
        .width_o(dec_width)
    );

    // masks the operand to its width so unused bits never leak into flags
    function [31:0] width_mask;
        input [1:0] w;
        begin
            case (w)
                `W_BYTE: width_mask = 32'h000000FF;
                `W_WORD: width_mask = 32'h0000FFFF;
                default: width_mask = 32'hFFFFFFFF;
            endcase
        end
    endfunction

    function sign_of;
        input [1:0] w;
        input [31:0] v;
        begin
            case (w)
                `W_BYTE: sign_of = v[7];
                `W_WORD: sign_of = v[15];
                default: sign_of = v[31];
            endcase
        end
    endfunction

    // ****************************************************************
    // state machine
    // ****************************************************************
    localparam ST_IDLE = 2'h0;
    localparam ST_SHIFT = 2'h1;
    localparam ST_TAIL = 2'h2;

    reg [1:0] state;
    reg [1:0] kind;
    reg [1:0] width;
    reg [4:0] remain;
    reg [5:0] tail;
    reg fill_bit;
    reg [31:0] data;
    reg carry;
    reg sticky;
    reg zero;

    // immediate counts sit below 16; anything else names a register
    wire count_is_imm = (count_byte_i <= `IMM_MAX);
    wire [4:0] start_count = count_is_imm ? count_byte_i[4:0]
                                          : count_reg_data_i[4:0];
    wire [31:0] masked_op = operand_i & width_mask(dec_width);
    wire top_bit = sign_of(width, data);

    reg [31:0] next_data;
    reg next_carry;
    reg next_sticky;

    // one shift step; sticky sees the carry held before this step
    always @* begin
        next_data = data;
        next_carry = carry;
        next_sticky = sticky;
        case (kind)
            `K_LEFT: begin
                next_carry = top_bit;
                next_data = (data << 1) & width_mask(width);
            end
            `K_LRIGHT: begin
                next_carry = data[0];
                next_sticky = sticky | carry;
                next_data = data >> 1;
            end
            `K_ARIGHT: begin
                next_carry = data[0];
                next_sticky = sticky | carry;
                next_data = data >> 1;
                case (width)
                    `W_BYTE: next_data[7] = fill_bit;
                    `W_WORD: next_data[15] = fill_bit;
                    default: next_data[31] = fill_bit;
                endcase
            end
            default: next_data = data;
        endcase
    end

    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            kind <= `K_LEFT;
            width <= `W_WORD;
            remain <= 5'h00;
            tail <= 6'h00;
            fill_bit <= 1'b0;
            data <= 32'h00000000;
            carry <= 1'b0;
            sticky <= 1'b0;
            zero <= 1'b0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            illegal_o <= 1'b0;
            result_o <= 32'h00000000;
            carry_flag_o <= 1'b0;
            sticky_flag_o <= 1'b0;
            zero_flag_o <= 1'b0;
            write_result_o <= 1'b0;
            length_o <= 2'h0;
            states_o <= 6'h00;
            count_reg_addr_o <= 8'h00;
        end else if (enable_i) begin
            done_o <= 1'b0;
            write_result_o <= 1'b0;
            illegal_o <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (start_i && !dec_valid) begin
                        illegal_o <= 1'b1;
                    end else if (start_i && dec_kind == `K_SET_CARRY_OP) begin
                        // four states, only carry changes
                        carry <= 1'b1;
                        sticky <= sticky_i;
                        zero <= zero_i;
                        kind <= dec_kind;
                        length_o <= `SET_CARRY_OP_BYTES;
                        states_o <= `SET_CARRY_OP_STATES;
                        tail <= `SET_CARRY_OP_STATES - 6'h02;
                        busy_o <= 1'b1;
                        state <= ST_TAIL;
                    end else if (start_i) begin
                        kind <= dec_kind;
                        width <= dec_width;
                        data <= masked_op;
                        fill_bit <= sign_of(dec_width, masked_op);
                        remain <= start_count;
                        // an old carry was never shifted in, so a right
                        // shift must not let it set sticky on step one
                        carry <= (dec_kind != `K_LEFT && start_count != 5'h00)
                                 ? 1'b0 : carry_i;
                        zero <= zero_i;
                        // right shifts restart sticky; left leaves it
                        sticky <= (dec_kind == `K_LEFT) ? sticky_i
                                                         : 1'b0;
                        count_reg_addr_o <= count_byte_i;
                        length_o <= `SHIFT_BYTES;
                        states_o <= (start_count == 5'h00)
                                    ? `ZERO_SHIFT_STATES
                                    : `SHIFT_BASE_STATES
                                      + {1'b0, start_count};
                        // setup state plus final state; the rest is tail
                        tail <= (start_count == 5'h00)
                                ? `ZERO_SHIFT_STATES - 6'h02
                                : `SHIFT_BASE_STATES - 6'h02;
                        busy_o <= 1'b1;
                        state <= (start_count == 5'h00) ? ST_TAIL : ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    data <= next_data;
                    carry <= next_carry;
                    sticky <= next_sticky;
                    remain <= remain - 5'h01;
                    if (remain == 5'h01) begin
                        state <= ST_TAIL;
                    end
                end
                ST_TAIL: begin
                    if (tail == 6'h00) begin
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                        carry_flag_o <= carry;
                        sticky_flag_o <= sticky;
                        if (kind == `K_SET_CARRY_OP) begin
                            zero_flag_o <= zero;
                        end else begin
                            result_o <= data;
                            write_result_o <= 1'b1;
                            zero_flag_o <= (data == 32'h00000000);
                        end
                        state <= ST_IDLE;
                    end else begin
                        tail <= tail - 6'h01;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

endmodule // shift_and_carry_unit
`default_nettype wire

// ---- verilog/shift_decode.v ----
/*
 * opcode decoder for the shift and carry unit.
 * assumes a registered opcode from the instruction fetch logic.
 */
`timescale 1ns/1ps
`default_nettype none
`include "shift_unit_consts.vh"

module shift_decode (
    input wire [7:0] opcode_i,
    output reg valid_o,
    output reg [1:0] kind_o,
    output reg [1:0] width_o
);

    always @* begin
        valid_o = 1'b1;
        kind_o = `K_LEFT;
        width_o = `W_WORD;
        case (opcode_i)
            `OP_SET_CARRY: kind_o = `K_SET_CARRY_OP;
            `OP_LEFT_WORD: width_o = `W_WORD;
            `OP_LEFT_BYTE: width_o = `W_BYTE;
            `OP_LEFT_DOUBLE: width_o = `W_DOUBLE;
            `OP_LRIGHT_WORD: kind_o = `K_LRIGHT;
            `OP_LRIGHT_BYTE: begin
                kind_o = `K_LRIGHT;
                width_o = `W_BYTE;
            end
            `OP_ARIGHT_WORD: kind_o = `K_ARIGHT;
            `OP_ARIGHT_BYTE: begin
                kind_o = `K_ARIGHT;
                width_o = `W_BYTE;
            end
            `OP_ARIGHT_DOUBLE: begin
                kind_o = `K_ARIGHT;
                width_o = `W_DOUBLE;
            end
            default: valid_o = 1'b0;
        endcase
    end

endmodule // shift_decode
`default_nettype wire
